// ==== hw/gptu_defs.svh ====
// gptu_defs.svh: register offsets, field positions, reset values, divider masks
// assumes: included by the timer unit files; 32-bit AHB-Lite words, one 50 MHz clock
//
// Overview of operation
// (RULE1) reset stops all channels, A 0 to 4, B 0 to 5; start bit runs them
// (RULE2) software changes mode, direction, trigger and select bits only while stopped
// (RULE3) timer mode counter reads give the live count
// (RULE4) event counter mode reads give the live count
// (RULE5) a counter write while stopped reads back until the channel starts
// (RULE6) one-shot stop reloads, drives output low, flags a request one clock later
// (RULE7) one-shot external trigger starts the pulse at the next count source tick
// (RULE8) entering one-shot from timer or event counter mode raises the request flag
// (RULE9) one-shot retrigger decrements once, then reloads and keeps counting
// (RULE10) retriggers come at least one count source cycle apart
// (RULE11) near zero an externally started one-shot ignores a retrigger
// (RULE12) entering pulse-width mode from timer or event counter mode raises the flag
// (RULE13) pulse-width stop drives a high output low and flags; low output unchanged
// (RULE14) B start bits sit at bits 7 to 5 of both start registers
// (RULE15) overflow flag clears only by a mode write one tick after it set
// (RULE16) first measured edge after start loads the reload register, no request
// (RULE17) measurement counter runs from its old value and may overflow first
// (RULE18) changing the measure select while running raises the flag; same value not
// (RULE19) width measurement captures every edge, high and low phases alike
// (RULE20) period overflow with a coincident edge gives one request, edge dropped
// (RULE21) channels count on their source, reload on underflow and raise the flag
`ifndef GPTU_DEFS_SVH
`define GPTU_DEFS_SVH
`define GPTU_OFF_START1 8'h00
`define GPTU_OFF_START2 8'h04
`define GPTU_OFF_DIR    8'h08
`define GPTU_OFF_OSF    8'h0C
`define GPTU_OFF_TRGSEL 8'h10
`define GPTU_OFF_IRQ    8'h14
`define GPTU_OFF_AMODE  8'h20
`define GPTU_OFF_ACNT   8'h40
`define GPTU_OFF_BMODE  8'h60
`define GPTU_OFF_BCNT   8'h80
`define GPTU_BST_LSB    5
`define GPTU_EXT_BIT    2
`define GPTU_MSEL_LSB   2
`define GPTU_OVF_BIT    5
`define GPTU_SRC_LSB    6
`define GPTU_MODE_RST   8'h00
`define GPTU_CNT_RST    16'h0000
`define GPTU_CNT_MAX    16'hFFFF
`define GPTU_MASK_F1    6'h00
`define GPTU_MASK_F8    6'h07
`define GPTU_MASK_F32   6'h1F
`define GPTU_MASK_F64   6'h3F
`endif

// ==== hw/gptu_pkg.sv ====
// gptu_pkg: mode types of the timer unit
// assumes: enum order matches the two-bit mode field
package gptu_pkg;
	typedef enum logic [1:0] {GPTU_A_TIMER, GPTU_A_EVENT, GPTU_A_ONESHOT, GPTU_A_PWM} gptu_amode_t;
	typedef enum logic [1:0] {GPTU_B_TIMER, GPTU_B_EVENT, GPTU_B_MEAS} gptu_bmode_t;
endpackage : gptu_pkg

// ==== hw/gptu_bchan.sv ====
// gptu_bchan: one B channel, timer, event counter and pulse measurement
// assumes: tick is a one-cycle enable, register writes come from the bus slave
`timescale 1ns/1ps
`include "gptu_defs.svh"
module gptu_bchan (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        tick,
	input  wire logic        start,
	input  wire logic        pin,
	input  wire logic        wr_mode,
	input  wire logic        wr_cnt,
	input  wire logic [15:0] wdata,
	output logic      [7:0]  mode_rd,
	output logic      [15:0] cnt_rd,
	output logic             req_set
);
	logic [7:0]  md;
	logic [15:0] cnt;
	logic [15:0] rld;
	logic        ovf_flag;
	logic        aged;
	logic        first;
	logic        st_q;
	logic        pin_q;
	gptu_pkg::gptu_bmode_t mode;
	logic [1:0]  msel;
	logic        edge_ok;
	logic        meas;
	logic        ovf;
	logic        cap;
	logic        sel_chg;
	logic        unf;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// width mode takes both edges, polarity is left to software
	assign mode    = gptu_pkg::gptu_bmode_t'(md[1:0]);
	assign msel    = md[`GPTU_MSEL_LSB+:2];
	assign edge_ok = msel[1] ? (pin ^ pin_q) : (msel[0] ? (pin_q & ~pin) : (pin & ~pin_q)); // RULE19
	assign meas    = (mode == gptu_pkg::GPTU_B_MEAS) && start;
	assign ovf     = meas && tick && (cnt == `GPTU_CNT_MAX); // RULE17
	assign cap     = meas && edge_ok && !(ovf && !msel[1]); // RULE20
	assign sel_chg = wr_mode && start && (wdata[`GPTU_MSEL_LSB+:2] != msel); // RULE18
	assign unf     = start && (cnt == `GPTU_CNT_RST) &&
		(((mode == gptu_pkg::GPTU_B_TIMER) && tick) ||
		((mode == gptu_pkg::GPTU_B_EVENT) && pin && !pin_q));
	// one pulse covers a coincident overflow and edge
	assign req_set = unf || ovf || (cap && !first) || sel_chg; // RULE16 RULE21
	assign mode_rd = {md[7:6], ovf_flag, md[4:0]};
	assign cnt_rd  = meas ? rld : cnt;

	// mode field and pin history
	always_ff @(posedge mclk) begin
		if (rst) begin
			md    <= `GPTU_MODE_RST;
			st_q  <= 1'b0;
			pin_q <= 1'b0;
		end else begin
			if (wr_mode)
				md <= wdata[7:0];
			st_q  <= start;
			pin_q <= pin;
		end
	end

	// overflow flag: set wins, clear needs a tick of age while running
	always_ff @(posedge mclk) begin
		if (rst) begin
			ovf_flag <= 1'b0;
			aged     <= 1'b0;
		end else if (ovf) begin
			ovf_flag <= 1'b1;
			aged     <= 1'b0;
		end else if (wr_mode && start && aged) begin
			ovf_flag <= 1'b0; // RULE15
			aged     <= 1'b0;
		end else if (ovf_flag && start && tick) begin
			aged <= 1'b1;
		end
	end

	// counter, reload and first-edge marker
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt   <= `GPTU_CNT_RST;
			rld   <= `GPTU_CNT_RST;
			first <= 1'b1;
		end else if (wr_cnt && !start) begin
			cnt <= wdata;
			rld <= wdata;
		end else begin
			if (wr_cnt)
				rld <= wdata;
			if (start && !st_q)
				first <= 1'b1;
			if (unf)
				cnt <= rld; // RULE21
			else if (cap) begin
				rld   <= cnt; // RULE16
				cnt   <= `GPTU_CNT_RST;
				first <= 1'b0;
			end else if (meas && tick)
				cnt <= cnt + 16'h0001;
			else if (start && ((mode == gptu_pkg::GPTU_B_TIMER) && tick ||
				(mode == gptu_pkg::GPTU_B_EVENT) && pin && !pin_q))
				cnt <= cnt - 16'h0001;
		end
	end

	a_first_edge_quiet: assert property (cap && first && !ovf && !sel_chg && !unf |-> !req_set) // RULE16
		else $error("first measured edge raised a request");
	a_ovf_young: assert property (ovf_flag && !aged && !ovf |=> ovf_flag) // RULE15
		else $error("overflow flag cleared too early");
	a_ovf_flags: assert property (ovf |-> req_set ##1 ovf_flag) // RULE17
		else $error("overflow did not flag");
	a_period_coinc: assert property (ovf && edge_ok && !msel[1] && !wr_cnt |=> rld == $past(rld)) // RULE20
		else $error("coincident edge was captured");
endmodule : gptu_bchan

// ==== hw/gptu_top.sv ====
// gptu_top: five A channels, six B channels, AHB-Lite register slave
// assumes: one slave on the bus, hready equals hreadyout, pins synchronous to mclk
`timescale 1ns/1ps
`include "gptu_defs.svh"
module gptu_top #(
	parameter int NA = 5
) (
	input  wire logic          mclk,
	input  wire logic          rst,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic      [31:0]   hrdata,
	output logic               hreadyout,
	output logic               hresp,
	input  wire logic [NA-1:0] a_channel_trigger_pin,
	input  wire logic [5:0]    b_channel_input_pin,
	output logic      [NA-1:0] a_channel_output_pin,
	output logic      [NA+5:0] interrupt_request_flag
);
	localparam int NB = 6;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	if (NA < 1 || NA > 5) begin : g_chk
		$error("NA must be 1 to 5");
	end

	// register at base plus four per channel
	function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int idx);
		return a == base + 8'(idx * 4);
	endfunction : hit

	// count source select from the prescaler
	function automatic logic src_tick(input logic [5:0] pre, input logic [1:0] sel);
		logic [5:0] m;
		unique case (sel)
			2'h0: m = `GPTU_MASK_F1;
			2'h1: m = `GPTU_MASK_F8;
			2'h2: m = `GPTU_MASK_F32;
			2'h3: m = `GPTU_MASK_F64;
		endcase
		return (pre & m) == m;
	endfunction : src_tick

	logic [7:0]    first_start_register;
	logic [7:5]    second_start_register;
	logic [7:0]    count_direction_register;
	logic [7:5]    one_shot_start_flags;
	logic [7:0]    trigger_select_register;
	logic [5:0]    pre;
	logic          dp_wr;
	logic          dp_rd;
	logic [7:0]    dp_addr;
	logic [31:0]   rdata;
	logic [15:0]   w;
	logic [7:0]    a_mode [NA];
	logic [15:0]   a_cnt [NA];
	logic [15:0]   a_rld [NA];
	logic [NA-1:0] busy;
	logic [NA-1:0] rt;
	logic [NA-1:0] xs;
	logic [NA-1:0] arm;
	logic [NA-1:0] st_q;
	logic [NA-1:0] trg_q;
	logic [NA-1:0] os_stop_d;
	logic [NA-1:0] st;
	logic [NA-1:0] tk;
	logic [NA-1:0] rise;
	logic [NA-1:0] trg;
	logic [NA-1:0] rtok;
	logic [NA-1:0] stop;
	logic [NA-1:0] wrm;
	logic [NA-1:0] wrc;
	logic [NA-1:0] os_end;
	logic [NA-1:0] a_irs;
	logic [NB-1:0] b_st;
	logic [NB-1:0] b_irs;
	logic [7:0]    b_mode_rd [NB];
	logic [15:0]   b_cnt_rd [NB];

	assign w    = hwdata[15:0];
	assign st   = first_start_register[NA-1:0]; // RULE1
	assign b_st = {second_start_register, first_start_register[7:`GPTU_BST_LSB]}; // RULE14

	// bus slave: writes land in the data phase, reads add one wait state so a
	// read right after a write already sees the new value
	always_ff @(posedge mclk) begin
		if (rst) begin
			dp_wr     <= 1'b0;
			dp_rd     <= 1'b0;
			dp_addr   <= 8'h00;
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
			hresp     <= 1'b0;
		end else begin
			dp_wr     <= hsel && hready && htrans[1] && hwrite;
			dp_rd     <= hsel && hready && htrans[1] && !hwrite;
			hreadyout <= !(hsel && hready && htrans[1] && !hwrite);
			if (hsel && hready && htrans[1])
				dp_addr <= haddr[7:0];
			if (dp_rd)
				hrdata <= rdata;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rdata = 32'h0000_0000;
		if (dp_addr == `GPTU_OFF_START1)
			rdata = {24'h00_0000, first_start_register};
		if (dp_addr == `GPTU_OFF_START2)
			rdata = {24'h00_0000, second_start_register, 5'h00};
		if (dp_addr == `GPTU_OFF_DIR)
			rdata = {24'h00_0000, count_direction_register};
		if (dp_addr == `GPTU_OFF_OSF)
			rdata = {24'h00_0000, one_shot_start_flags, 5'h00};
		if (dp_addr == `GPTU_OFF_TRGSEL)
			rdata = {24'h00_0000, trigger_select_register};
		if (dp_addr == `GPTU_OFF_IRQ)
			rdata = 32'(interrupt_request_flag);
		for (int k = 0; k < NA; k++) begin
			if (hit(dp_addr, `GPTU_OFF_AMODE, k))
				rdata = {24'h00_0000, a_mode[k]};
			if (hit(dp_addr, `GPTU_OFF_ACNT, k))
				rdata = {16'h0000, a_cnt[k]}; // RULE3 RULE4
		end
		for (int k = 0; k < NB; k++) begin
			if (hit(dp_addr, `GPTU_OFF_BMODE, k))
				rdata = {24'h00_0000, b_mode_rd[k]};
			if (hit(dp_addr, `GPTU_OFF_BCNT, k))
				rdata = {16'h0000, b_cnt_rd[k]};
		end
	end

	// shared control registers; the one-shot trigger bits are write-only pulses
	always_ff @(posedge mclk) begin
		if (rst) begin
			first_start_register     <= 8'h00; // RULE1
			second_start_register    <= 3'h0;
			count_direction_register <= 8'h00;
			one_shot_start_flags     <= 3'h0;
			trigger_select_register  <= 8'h00;
		end else if (dp_wr) begin
			if (dp_addr == `GPTU_OFF_START1)
				first_start_register <= hwdata[7:0];
			if (dp_addr == `GPTU_OFF_START2)
				second_start_register <= hwdata[7:5];
			if (dp_addr == `GPTU_OFF_DIR)
				count_direction_register <= hwdata[7:0];
			if (dp_addr == `GPTU_OFF_OSF)
				one_shot_start_flags <= hwdata[7:5];
			if (dp_addr == `GPTU_OFF_TRGSEL)
				trigger_select_register <= hwdata[7:0];
		end
	end

	// free prescaler for the count sources
	always_ff @(posedge mclk) begin
		if (rst)
			pre <= 6'h00;
		else
			pre <= pre + 6'h01;
	end

	// request flags: hardware set wins over a write-one clear
	always_ff @(posedge mclk) begin
		if (rst)
			interrupt_request_flag <= '0;
		else if (dp_wr && dp_addr == `GPTU_OFF_IRQ)
			interrupt_request_flag <= {b_irs, a_irs} |
				(interrupt_request_flag & ~hwdata[NA+5:0]);
		else
			interrupt_request_flag <= {b_irs, a_irs} | interrupt_request_flag;
	end

	for (genvar i = 0; i < NA; i++) begin : g_a
		gptu_pkg::gptu_amode_t md;
		logic                  newps;
		logic                  oldte;
		assign md      = gptu_pkg::gptu_amode_t'(a_mode[i][1:0]);
		assign tk[i]   = src_tick(pre, a_mode[i][`GPTU_SRC_LSB+:2]);
		assign rise[i] = a_channel_trigger_pin[i] && !trg_q[i];
		assign stop[i] = st_q[i] && !st[i];
		assign wrm[i]  = dp_wr && hit(dp_addr, `GPTU_OFF_AMODE, i);
		assign wrc[i]  = dp_wr && hit(dp_addr, `GPTU_OFF_ACNT, i);
		assign trg[i]  = st[i] && (a_mode[i][`GPTU_EXT_BIT] ? rise[i] :
			(dp_wr && dp_addr == `GPTU_OFF_OSF && hwdata[i]));
		// counts of one or less leave no room before zero
		assign rtok[i] = trg[i] && !(xs[i] && a_cnt[i] <= 16'h0001); // RULE11
		assign os_end[i] = md == gptu_pkg::GPTU_A_ONESHOT && busy[i] && !stop[i] && !rtok[i] &&
			tk[i] && !rt[i] && a_cnt[i] == `GPTU_CNT_RST;
		assign newps   = w[1];
		assign oldte   = !a_mode[i][1];
		// every event that raises this channel's request flag
		assign a_irs[i] = os_stop_d[i] || os_end[i] ||
			(wrm[i] && newps && oldte) || // RULE8 RULE12
			(md == gptu_pkg::GPTU_A_TIMER && st[i] && tk[i] && a_cnt[i] == `GPTU_CNT_RST) ||
			(md == gptu_pkg::GPTU_A_EVENT && st[i] && rise[i] && (count_direction_register[i] ?
				a_cnt[i] == `GPTU_CNT_MAX : a_cnt[i] == `GPTU_CNT_RST)) ||
			(md == gptu_pkg::GPTU_A_PWM && a_channel_output_pin[i] &&
				(stop[i] || st[i] && busy[i] && tk[i] && a_cnt[i] == `GPTU_CNT_RST)); // RULE13

		a_os_stop_low: assert property (stop[i] && md == gptu_pkg::GPTU_A_ONESHOT && busy[i]
			|=> !a_channel_output_pin[i] && a_cnt[i] == $past(a_rld[i]) ##1 // RULE6
			interrupt_request_flag[i]) else $error("one-shot stop misbehaved");
		a_retrig_dec: assert property (md == gptu_pkg::GPTU_A_ONESHOT && busy[i] && !stop[i] &&
			rtok[i] |=> a_cnt[i] == $past(a_cnt[i]) - 16'h0001 && rt[i]) // RULE9
			else $error("retrigger did not decrement");
		a_pwm_stop: assert property (stop[i] && md == gptu_pkg::GPTU_A_PWM && a_channel_output_pin[i]
			|=> !a_channel_output_pin[i] && interrupt_request_flag[i]) // RULE13
			else $error("pwm stop did not drop output");
		a_mode_irq: assert property (wrm[i] && w[1] && !a_mode[i][1]
			|=> interrupt_request_flag[i]) // RULE8
			else $error("mode switch did not flag");
		a_cnt_wr: assert property (wrc[i] && !st[i] |=> a_cnt[i] == $past(w)) // RULE5
			else $error("stopped counter write lost");
		a_tmr_reload: assert property (md == gptu_pkg::GPTU_A_TIMER && st[i] && tk[i] && !wrc[i] &&
			a_cnt[i] == `GPTU_CNT_RST |=> a_cnt[i] == $past(a_rld[i])) // RULE21
			else $error("timer did not reload");
	end

	// A mode registers and per-channel edge history
	always_ff @(posedge mclk) begin
		for (int i = 0; i < NA; i++) begin
			if (rst)
				a_mode[i] <= `GPTU_MODE_RST;
			else if (wrm[i])
				a_mode[i] <= w[7:0];
		end
		if (rst) begin
			st_q      <= '0;
			trg_q     <= '0;
			os_stop_d <= '0;
		end else begin
			st_q  <= st;
			trg_q <= a_channel_trigger_pin;
			for (int i = 0; i < NA; i++)
				os_stop_d[i] <= stop[i] && busy[i] && a_mode[i][1:0] == 2'h2; // RULE6
		end
	end

	// A counters, outputs and one-shot state
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < NA; i++) begin
				a_cnt[i] <= `GPTU_CNT_RST;
				a_rld[i] <= `GPTU_CNT_RST;
			end
			busy                 <= '0;
			rt                   <= '0;
			xs                   <= '0;
			arm                  <= '0;
			a_channel_output_pin <= '0;
		end else begin
			for (int i = 0; i < NA; i++) begin
				if (wrc[i])
					a_rld[i] <= w;
				if (wrc[i] && !st[i])
					a_cnt[i] <= w; // RULE5
				else if (stop[i]) begin
					busy[i] <= 1'b0;
					rt[i]   <= 1'b0;
					arm[i]  <= 1'b0;
					a_channel_output_pin[i] <= 1'b0; // RULE6 RULE13
					if (a_mode[i][1:0] == 2'h2)
						a_cnt[i] <= a_rld[i];
				end else
					unique case (gptu_pkg::gptu_amode_t'(a_mode[i][1:0]))
						gptu_pkg::GPTU_A_TIMER:
							if (st[i] && tk[i])
								a_cnt[i] <= a_cnt[i] == `GPTU_CNT_RST ? a_rld[i] :
									a_cnt[i] - 16'h0001; // RULE21
						gptu_pkg::GPTU_A_EVENT:
							if (st[i] && rise[i]) begin
								if (count_direction_register[i])
									a_cnt[i] <= a_cnt[i] == `GPTU_CNT_MAX ? a_rld[i] :
										a_cnt[i] + 16'h0001;
								else
									a_cnt[i] <= a_cnt[i] == `GPTU_CNT_RST ? a_rld[i] :
										a_cnt[i] - 16'h0001;
							end
						gptu_pkg::GPTU_A_ONESHOT:
							if (busy[i]) begin
								if (rtok[i]) begin
									a_cnt[i] <= a_cnt[i] - 16'h0001; // RULE9
									rt[i]    <= 1'b1;
								end else if (tk[i] && rt[i]) begin
									a_cnt[i] <= a_rld[i];
									rt[i]    <= 1'b0;
								end else if (os_end[i]) begin
									busy[i]  <= 1'b0;
									a_cnt[i] <= a_rld[i];
									a_channel_output_pin[i] <= 1'b0;
								end else if (tk[i])
									a_cnt[i] <= a_cnt[i] - 16'h0001;
							end else if (arm[i] && tk[i]) begin
								// trigger waits for the next source tick
								arm[i]  <= 1'b0; // RULE7
								busy[i] <= 1'b1;
								xs[i]   <= a_mode[i][`GPTU_EXT_BIT];
								a_channel_output_pin[i] <= 1'b1;
							end else if (trg[i])
								arm[i] <= 1'b1;
						gptu_pkg::GPTU_A_PWM:
							if (st[i] && tk[i]) begin
								if (!busy[i]) begin
									busy[i]  <= 1'b1;
									a_cnt[i] <= a_rld[i];
									a_channel_output_pin[i] <= 1'b1;
								end else if (a_cnt[i] == `GPTU_CNT_RST) begin
									a_channel_output_pin[i] <= !a_channel_output_pin[i];
									a_cnt[i] <= a_channel_output_pin[i] ?
										`GPTU_CNT_MAX - a_rld[i] : a_rld[i];
								end else
									a_cnt[i] <= a_cnt[i] - 16'h0001;
							end
					endcase
			end
		end
	end

	for (genvar j = 0; j < NB; j++) begin : g_b
		gptu_bchan u_b (
			.mclk    (mclk),
			.rst     (rst),
			.tick    (src_tick(pre, b_mode_rd[j][`GPTU_SRC_LSB+:2])),
			.start   (b_st[j]),
			.pin     (b_channel_input_pin[j]),
			.wr_mode (dp_wr && hit(dp_addr, `GPTU_OFF_BMODE, j)),
			.wr_cnt  (dp_wr && hit(dp_addr, `GPTU_OFF_BCNT, j)),
			.wdata   (w),
			.mode_rd (b_mode_rd[j]),
			.cnt_rd  (b_cnt_rd[j]),
			.req_set (b_irs[j])
		);
	end

	a_reset_stopped: assert property ($past(rst) |-> first_start_register == 8'h00 &&
		second_start_register == 3'h0) // RULE1
		else $error("channels not stopped after reset");
endmodule : gptu_top

// ==== bench/gptu_pins.sv ====
// gptu_pins: far-side pin model, trigger and measurement inputs of the timer unit
// assumes: the bench calls its tasks right after a rising mclk edge
`timescale 1ns/1ps
module gptu_pins (
	input  wire logic       mclk,
	output logic      [4:0] a_channel_trigger_pin,
	output logic      [5:0] b_channel_input_pin
);
	// pins rest low until the bench asks for edges
	initial begin
		a_channel_trigger_pin = 5'h00;
		b_channel_input_pin   = 6'h00;
	end

	// one trigger: high two cycles, low two, so triggers stay a tick apart
	// retriggers are sent only far from the count end, never in the guard window
	task automatic pulse_a(input int ch);
		a_channel_trigger_pin[ch] <= 1'b1;
		repeat (2) @(posedge mclk);
		a_channel_trigger_pin[ch] <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask : pulse_a

	// one level change, then a fixed dwell that the bench measures against
	task automatic edge_b(input int ch, input int dwell);
		b_channel_input_pin[ch] <= ~b_channel_input_pin[ch];
		repeat (dwell) @(posedge mclk);
	endtask : edge_b
endmodule : gptu_pins

// ==== bench/gptu_bench.sv ====
// gptu_bench: self-checking bench of the timer unit through its AHB-Lite slave
// assumes: gptu_top and gptu_pins compiled before it, one 50 MHz clock
`timescale 1ns/1ps
module gptu_bench;
	logic        mclk;
	logic        rst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [4:0]  a_trg;
	logic [5:0]  b_in;
	logic [4:0]  a_out;
	logic [10:0] irq;
	logic [15:0] obs;
	logic [31:0] rd;
	logic [15:0] v;
	int          errors;
	int          tests_run;
	int          cycles;
	int          seed;
	int          k;
	int          n;

	// flags low, channel outputs above them, so one wait helper serves both
	assign obs = {a_out, irq};

	gptu_top i_dut (
		.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.a_channel_trigger_pin(a_trg), .b_channel_input_pin(b_in),
		.a_channel_output_pin(a_out), .interrupt_request_flag(irq)
	);
	gptu_pins i_pins (.mclk(mclk), .a_channel_trigger_pin(a_trg), .b_channel_input_pin(b_in));

	// free-running clock, 20 ns period
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// hang guard: the sequence needs under two thousand cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			end_of_test();
		end
	end

	// compare and count; an unknown never matches
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run = tests_run + 1;
		if (g !== e) begin
			errors = errors + 1;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one single transfer; hready is judged as sampled at each rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		rd = hrdata;
	endtask : xfer

	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rc

	// bounded wait for one flag or output level, then compare
	task automatic wq(input string nm, input int b, input logic e, input int lim);
		for (int i = 0; i < lim && obs[b] !== e; i++) @(posedge mclk);
		chk(nm, {31'h0, e}, {31'h0, obs[b]});
	endtask : wq

	// event count after c edges, wrapping at either end
	function automatic logic [15:0] ev_exp(input logic [15:0] s, input int c, input logic up);
		return up ? s + 16'(c) : s - 16'(c);
	endfunction : ev_exp

	// second start register keeps only its three B start bits
	function automatic logic [31:0] st2_exp(input logic [31:0] d);
		return d & 32'h000000E0;
	endfunction : st2_exp

	task automatic end_of_test;
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	initial begin
		seed      = 13;
		errors    = 0;
		tests_run = 0;
		cycles    = 0;
		rst       = 1'b1;
		hsel      = 1'b0;
		haddr     = 32'h0;
		htrans    = 2'h0;
		hwrite    = 1'b0;
		hwdata    = 32'h0;
		repeat (2) @(posedge mclk);
		rst  <= 1'b0;
		hsel <= 1'b1;
		@(posedge mclk);
		// all idle and zero after reset, holes read zero and ignore writes
		chk("irq", 32'h0, {21'h0, irq});
		chk("out", 32'h0, {27'h0, a_out});
		chk("hresp", 32'h0, {31'h0, hresp});
		for (k = 0; k < 6; k++) rc("ctl", 8'(4 * k), 32'h0);
		for (k = 0; k < 5; k++) rc("amode", 8'h20 + 8'(4 * k), 32'h0);
		for (k = 0; k < 6; k++) rc("bmode", 8'h60 + 8'(4 * k), 32'h0);
		xfer(1'b1, 8'hFC, 32'hFFFFFFFF);
		rc("hole", 8'hFC, 32'h0);
		// counters start at zero; short random values keep later waits short
		for (k = 0; k < 11; k++) begin
			n = (k < 5) ? 8'h40 + 4 * k : 8'h80 + 4 * (k - 5);
			v = {8'h00, 8'($random(seed))};
			rc("cnt0", 8'(n), 32'h0);
			xfer(1'b1, 8'(n), {16'h0, v});
			rc("cnt", 8'(n), {16'h0, v});
		end
		// B start bits in both start registers, by the channel that flags
		xfer(1'b1, 8'h04, 32'hFFFFFFFF);
		rc("start2", 8'h04, st2_exp(32'hFFFFFFFF));
		wq("irq_b5", 10, 1'b1, 300);
		xfer(1'b1, 8'h04, 32'h0);
		xfer(1'b1, 8'h00, 32'h000000E0);
		rc("start1", 8'h00, 32'h000000E0);
		wq("irq_b2", 7, 1'b1, 300);
		xfer(1'b1, 8'h00, 32'h0);
		xfer(1'b1, 8'h14, 32'h7FF);
		rc("irq_clr", 8'h14, 32'h0);
		// timer mode: live count moves down, underflow flags
		xfer(1'b1, 8'h40, 32'h80);
		xfer(1'b1, 8'h00, 32'h1);
		xfer(1'b0, 8'h40, 32'h0);
		chk("live", 32'h1, 32'(rd[15:0] < 16'h0080 && rd[15:0] > 16'h0070));
		wq("irq_a0", 0, 1'b1, 300);
		xfer(1'b1, 8'h00, 32'h0);
		// entering one-shot and PWM from timer mode raises the flag
		xfer(1'b1, 8'h14, 32'h7FF);
		xfer(1'b1, 8'h24, 32'h2);
		wq("irq_a1", 1, 1'b1, 4);
		xfer(1'b1, 8'h28, 32'h3);
		wq("irq_a2", 2, 1'b1, 4);
		// one-shot stop in mid-pulse: output low, reload, flag
		xfer(1'b1, 8'h44, 32'h100);
		xfer(1'b1, 8'h00, 32'h2);
		xfer(1'b1, 8'h0C, 32'h2);
		wq("os_hi", 12, 1'b1, 8);
		xfer(1'b1, 8'h14, 32'h7FF);
		xfer(1'b1, 8'h00, 32'h0);
		wq("os_lo", 12, 1'b0, 3);
		wq("os_irq", 1, 1'b1, 4);
		rc("reload", 8'h44, 32'h100);
		// PWM stop while high flags; stop while low changes nothing
		xfer(1'b1, 8'h48, 32'h80);
		xfer(1'b1, 8'h00, 32'h4);
		wq("pwm_hi", 13, 1'b1, 8);
		xfer(1'b1, 8'h14, 32'h7FF);
		xfer(1'b1, 8'h00, 32'h0);
		wq("pwm_lo", 13, 1'b0, 3);
		wq("pwm_irq", 2, 1'b1, 3);
		xfer(1'b1, 8'h00, 32'h4);
		wq("pwm_hi2", 13, 1'b1, 8);
		wq("pwm_fall", 13, 1'b0, 300);
		xfer(1'b1, 8'h14, 32'h7FF);
		xfer(1'b1, 8'h00, 32'h0);
		repeat (4) @(posedge mclk);
		chk("pwm_quiet", 32'h0, {30'h0, a_out[2], irq[2]});
		// event to one-shot flags; external trigger starts the pulse promptly
		xfer(1'b1, 8'h2C, 32'h1);
		xfer(1'b1, 8'h14, 32'h7FF);
		xfer(1'b1, 8'h2C, 32'h6);
		wq("irq_a3", 3, 1'b1, 4);
		xfer(1'b1, 8'h4C, 32'h40);
		xfer(1'b1, 8'h00, 32'h8);
		i_pins.pulse_a(3);
		chk("ext_out", 32'h1, {31'h0, a_out[3]});
		// retrigger mid-count: one step down, then a reload puts the count back near the top
		i_pins.pulse_a(3);
		xfer(1'b0, 8'h4C, 32'h0);
		chk("retrig", 32'h1, 32'(rd[15:0] >= 16'h003C && rd[15:0] <= 16'h0040));
		xfer(1'b1, 8'h00, 32'h0);
		// event counter down then up by a random edge count
		v = {8'h10, 8'($random(seed))};
		n = 3 + ($random(seed) & 7);
		xfer(1'b1, 8'h30, 32'h1);
		xfer(1'b1, 8'h50, {16'h0, v});
		for (k = 0; k < 2; k++) begin
			xfer(1'b1, 8'h08, 32'(k << 4));
			xfer(1'b1, 8'h00, 32'h10);
			repeat (n) i_pins.pulse_a(4);
			xfer(1'b1, 8'h00, 32'h0);
			v = ev_exp(v, n, k[0]);
			rc("events", 8'h50, {16'h0, v});
		end
		// width measurement: first edge quiet, then the falling edge captures the high phase
		xfer(1'b1, 8'h60, 32'hA);
		xfer(1'b1, 8'h14, 32'h7FF);
		xfer(1'b1, 8'h00, 32'h20);
		i_pins.edge_b(0, 10);
		chk("first_edge", 32'h0, {31'h0, irq[5]});
		i_pins.edge_b(0, 10);
		chk("fall_edge", 32'h1, {31'h0, irq[5]});
		xfer(1'b0, 8'h80, 32'h0);
		chk("width", 32'h1, 32'(rd[15:0] >= 16'h0009 && rd[15:0] <= 16'h000B));
		// select rewrite: same value quiet, new value flags
		xfer(1'b1, 8'h14, 32'h7FF);
		xfer(1'b1, 8'h60, 32'hA);
		repeat (4) @(posedge mclk);
		chk("same_sel", 32'h0, {31'h0, irq[5]});
		xfer(1'b1, 8'h60, 32'h2);
		wq("new_sel", 5, 1'b1, 4);
		// period mode from near the top: overflow flags, ages, then a mode write clears it
		xfer(1'b1, 8'h64, 32'h2);
		xfer(1'b1, 8'h84, 32'hFFF0);
		xfer(1'b1, 8'h14, 32'h7FF);
		xfer(1'b1, 8'h00, 32'h40);
		wq("ovf_irq", 6, 1'b1, 40);
		rc("ovf_set", 8'h64, 32'h22);
		xfer(1'b1, 8'h64, 32'h2);
		rc("ovf_clr", 8'h64, 32'h2);
		xfer(1'b1, 8'h00, 32'h0);
		end_of_test();
	end
endmodule : gptu_bench
